// ### src/config_word_one_regs.svh
`ifndef CONFIG_WORD_ONE_REGS_SVH
`define CONFIG_WORD_ONE_REGS_SVH

// flash word addresses of configuration words one to four
`define CW_ADDR_LARGE_1     16'hABFE
`define CW_ADDR_SMALL_1     16'h57FE
`define CW_ADDR_STEP        16'h0002
`define CW_ADDR_LARGE_4     16'hABF8

// field positions of configuration word one
`define CW1_UPPER_MSB       23
`define CW1_UPPER_LSB       16
`define CW1_RSVD_BIT        15
`define CW1_SCAN_BIT        14
`define CW1_PROT_BIT        13
`define CW1_WPROT_BIT       12
`define CW1_DEBUG_BIT       11
`define CW1_UNIMP_HI_BIT    10
`define CW1_EMU_MSB         9
`define CW1_EMU_LSB         8
`define CW1_WDT_ON_BIT      7
`define CW1_WIN_OFF_BIT     6
`define CW1_UNIMP_LO_BIT    5
`define CW1_PRESCALE_BIT    4
`define CW1_POST_MSB        3
`define CW1_POST_LSB        0

// unprogrammed value and bits that always read one
`define CW1_ERASED          24'hFFFFFF
`define CW1_FORCE_ONE       24'hFF0420

// prescaler ratios
`define WDT_PRESCALE_HI     8'h80
`define WDT_PRESCALE_LO     8'h20

`endif

// ### src/config_word_one_pkg.sv
package config_word_one_pkg;
  typedef enum logic [1:0] {
    pair_none,
    pair_one,
    pair_two,
    pair_three
  } emu_pair_t;

  typedef enum {
    st_fetch,
    st_wait,
    st_latch,
    st_run
  } load_state_t;
endpackage

// ### src/config_word_one_decode.sv
`timescale 1ns/10ps
`include "config_word_one_regs.svh"

module config_word_one_decode (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        small_memory,
  output logic      [15:0] flash_addr,
  output logic             flash_rd,
  input  wire logic        flash_rd_valid,
  input  wire logic [23:0] flash_rd_data,
  input  wire logic        prog_wr,
  input  wire logic        prog_via_scan,
  input  wire logic [23:0] prog_data,
  output logic      [23:0] config_word_one,
  output logic             scan_port_on,
  output logic             code_protect_all_n,
  output logic             flash_write_protect_n,
  output logic             debug_mode,
  output logic      [1:0]  emu_pin_pair_sel,
  output logic             emu_pair_one,
  output logic             emu_pair_two,
  output logic             emu_pair_three,
  output logic             watchdog_on_cfg,
  output logic             window_mode_off,
  output logic             watchdog_prescale_sel,
  output logic      [7:0]  watchdog_prescale_ratio,
  output logic      [3:0]  watchdog_postscale_sel,
  output logic      [15:0] watchdog_postscale_ratio,
  output logic             core_reset_hold,
  output logic             watchdog_reset_hold
);

  ////////////////////////////////////////////////////////////////////////////////
  // load sequencer

  config_word_one_pkg::load_state_t state;
  config_word_one_pkg::load_state_t next_state;
  logic [1:0]  word_idx;
  logic [1:0]  next_word_idx;
  logic [23:0] word_one;
  logic [23:0] next_word_one;
  logic [15:0] next_flash_addr;
  logic        next_flash_rd;
  logic [15:0] base_addr;
  logic        strap_small;
  logic        next_strap_small;
  logic        small_sync_1;
  logic        small_sync_2;

  // strap pin crosses in through two flops; no reset so it settles while reset is held
  always_ff @(posedge clk) begin
    if (clk_en) begin
      small_sync_1 <= small_memory;
      small_sync_2 <= small_sync_1;
    end
  end

  always_comb begin
    base_addr = strap_small ? `CW_ADDR_SMALL_1 : `CW_ADDR_LARGE_1;
    next_state = state;
    next_word_idx = word_idx;
    next_word_one = word_one;
    next_flash_addr = flash_addr;
    next_flash_rd = 1'b0;
    next_strap_small = strap_small;
    unique case (state)
      config_word_one_pkg::st_fetch: begin
        next_strap_small = small_sync_2;
        next_flash_addr = (small_sync_2 ? `CW_ADDR_SMALL_1 : `CW_ADDR_LARGE_1)
                          - 16'(word_idx) * `CW_ADDR_STEP;
        next_flash_rd = 1'b1;
        next_state = config_word_one_pkg::st_wait;
      end
      config_word_one_pkg::st_wait: begin
        if (flash_rd_valid) begin
          if (word_idx == 2'h0) begin
            next_word_one = flash_rd_data | `CW1_FORCE_ONE;
          end
          if (word_idx == 2'h3) begin
            next_state = config_word_one_pkg::st_latch;
          end else begin
            next_word_idx = word_idx + 2'h1;
            next_flash_addr = base_addr - 16'(word_idx + 2'h1) * `CW_ADDR_STEP;
            next_flash_rd = 1'b1;
          end
        end
      end
      config_word_one_pkg::st_latch: begin
        next_state = config_word_one_pkg::st_run;
      end
      config_word_one_pkg::st_run: begin
        if (prog_wr) begin
          // program-once: bits can only clear
          next_word_one = (word_one & prog_data) | `CW1_FORCE_ONE;
          if (prog_via_scan) begin
            next_word_one[`CW1_SCAN_BIT] = word_one[`CW1_SCAN_BIT];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= config_word_one_pkg::st_fetch;
      word_idx <= 2'h0;
      word_one <= `CW1_ERASED;
      flash_addr <= 16'h0000;
      flash_rd <= 1'b0;
      strap_small <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      word_idx <= next_word_idx;
      word_one <= next_word_one;
      flash_addr <= next_flash_addr;
      flash_rd <= next_flash_rd;
      strap_small <= next_strap_small;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // decoded settings

  logic [15:0] next_post_ratio;
  logic        next_hold;
  logic        pair1;
  logic        pair2;
  logic        pair3;

  always_comb begin
    next_hold = (next_state != config_word_one_pkg::st_run);
    pair1 = next_word_one[`CW1_EMU_MSB:`CW1_EMU_LSB] == 2'h3;
    pair2 = next_word_one[`CW1_EMU_MSB:`CW1_EMU_LSB] == 2'h2;
    pair3 = next_word_one[`CW1_EMU_MSB:`CW1_EMU_LSB] == 2'h1;
    next_post_ratio = 16'h0001 << next_word_one[`CW1_POST_MSB:`CW1_POST_LSB];
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      config_word_one <= `CW1_ERASED;
      scan_port_on <= 1'b1;
      code_protect_all_n <= 1'b1;
      flash_write_protect_n <= 1'b1;
      debug_mode <= 1'b0;
      emu_pin_pair_sel <= 2'h3;
      emu_pair_one <= 1'b1;
      emu_pair_two <= 1'b0;
      emu_pair_three <= 1'b0;
      watchdog_on_cfg <= 1'b1;
      window_mode_off <= 1'b1;
      watchdog_prescale_sel <= 1'b1;
      watchdog_prescale_ratio <= `WDT_PRESCALE_HI;
      watchdog_postscale_sel <= 4'hF;
      watchdog_postscale_ratio <= 16'h8000;
      core_reset_hold <= 1'b1;
      watchdog_reset_hold <= 1'b1;
    end else if (clk_en) begin
      config_word_one <= next_word_one;
      scan_port_on <= next_word_one[`CW1_SCAN_BIT];
      code_protect_all_n <= next_word_one[`CW1_PROT_BIT];
      flash_write_protect_n <= next_word_one[`CW1_WPROT_BIT];
      debug_mode <= ~next_word_one[`CW1_DEBUG_BIT];
      emu_pin_pair_sel <= next_word_one[`CW1_EMU_MSB:`CW1_EMU_LSB];
      emu_pair_one <= pair1;
      emu_pair_two <= pair2;
      emu_pair_three <= pair3;
      watchdog_on_cfg <= next_word_one[`CW1_WDT_ON_BIT];
      window_mode_off <= next_word_one[`CW1_WIN_OFF_BIT];
      watchdog_prescale_sel <= next_word_one[`CW1_PRESCALE_BIT];
      watchdog_prescale_ratio <= next_word_one[`CW1_PRESCALE_BIT] ?
                                 `WDT_PRESCALE_HI : `WDT_PRESCALE_LO;
      watchdog_postscale_sel <= next_word_one[`CW1_POST_MSB:`CW1_POST_LSB];
      watchdog_postscale_ratio <= next_post_ratio;
      core_reset_hold <= next_hold;
      watchdog_reset_hold <= next_hold;
    end
  end

endmodule

// ### tb/config_word_one_decode_asserts.sv
`timescale 1ns/10ps
module config_word_one_decode_asserts (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        prog_wr,
  input wire logic        prog_via_scan,
  input wire logic [23:0] config_word_one,
  input wire logic        scan_port_on,
  input wire logic        code_protect_all_n,
  input wire logic        flash_write_protect_n,
  input wire logic        debug_mode,
  input wire logic [7:0]  watchdog_prescale_ratio,
  input wire logic [15:0] watchdog_postscale_ratio,
  input wire logic        core_reset_hold
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_forced_ones: assert property (
    (config_word_one & 24'hFF0420) == 24'hFF0420) else $error("forced bits low");
  a_scan_copy: assert property (
    scan_port_on == config_word_one[14]) else $error("scan enable");
  a_protect_pair: assert property (
    {code_protect_all_n, flash_write_protect_n} == config_word_one[13:12]) else $error("protect");
  a_debug_inv: assert property (
    debug_mode == !config_word_one[11]) else $error("debug");
  a_prescale_ratio: assert property (
    watchdog_prescale_ratio == (config_word_one[4] ? 8'h80 : 8'h20)) else $error("prescale");
  a_postscale_ratio: assert property (
    watchdog_postscale_ratio == 16'h0001 << config_word_one[3:0]) else $error("postscale");
  a_bits_only_clear: assert property (!core_reset_hold && !$past(core_reset_hold) |->
    (config_word_one & ~$past(config_word_one)) == 24'h000000) else $error("bit set");
  a_scan_lock: assert property (prog_wr && prog_via_scan && !core_reset_hold |=>
    $stable(scan_port_on)) else $error("scan changed");
endmodule

// ### tb/flash_model.sv
`timescale 1ns/10ps
module flash_model (
  input  wire logic        clk,
  input  wire logic        flash_rd,
  input  wire logic [15:0] flash_addr,
  input  wire logic [15:0] base,
  input  wire logic [23:0] word_one,
  input  wire logic [3:0]  lat,
  output logic             flash_rd_valid,
  output logic      [23:0] flash_rd_data
);
  logic        pend = 1'b0;
  logic [3:0]  cnt;
  logic [15:0] addr;
  initial {flash_rd_valid, flash_rd_data} = 25'h0000000;
  // data toggles every cycle outside a valid beat
  always @(posedge clk) begin
    flash_rd_valid <= 1'b0;
    flash_rd_data  <= ~flash_rd_data;
    if (flash_rd) begin
      pend <= 1'b1;
      cnt  <= lat;
      addr <= flash_addr;
    end else if (pend && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (pend) begin
      pend           <= 1'b0;
      flash_rd_valid <= 1'b1;
      flash_rd_data  <= (addr == base) ? word_one : {8'hFF, addr};
    end
  end
endmodule

// ### tb/config_word_one_decode_tb.sv
`timescale 1ns/10ps
module config_word_one_decode_tb;
  logic        clk = 1'b0, reset = 1'b1, small_memory = 1'b0, prog_wr = 1'b0, prog_via_scan = 1'b0;
  logic        flash_rd, flash_rd_valid, emu_pair_one, emu_pair_two, emu_pair_three, core_reset_hold;
  logic [3:0]  lat = 4'h0;
  logic [7:0]  watchdog_prescale_ratio;
  logic [15:0] base, flash_addr, watchdog_postscale_ratio;
  logic [15:0] addrs[$];
  logic [23:0] prog_data = 24'h000000, word_one = 24'h7FFFFF, w, flash_rd_data, config_word_one;
  logic [50:0] got, got2;
  logic        scan_port_on, code_protect_all_n, flash_write_protect_n, debug_mode;
  logic        watchdog_on_cfg, window_mode_off, watchdog_prescale_sel, watchdog_reset_hold;
  logic [1:0]  emu_pin_pair_sel;
  logic [3:0]  watchdog_postscale_sel;
  int          errors = 0, samples_checked = 0;
  assign base = small_memory ? 16'h57FE : 16'hABFE;
  assign got = {config_word_one, emu_pair_one, emu_pair_two, emu_pair_three,
                watchdog_prescale_ratio, watchdog_postscale_ratio};
  assign got2 = {37'h0, scan_port_on, code_protect_all_n, flash_write_protect_n, debug_mode,
                 emu_pin_pair_sel, watchdog_on_cfg, window_mode_off, watchdog_prescale_sel,
                 watchdog_postscale_sel, watchdog_reset_hold};
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) if (flash_rd) addrs.push_back(flash_addr);
  config_word_one_decode i_config_word_one_decode (.clk, .reset, .clk_en(1'b1), .small_memory,
    .flash_addr, .flash_rd, .flash_rd_valid, .flash_rd_data, .prog_wr, .prog_via_scan, .prog_data,
    .config_word_one, .scan_port_on, .code_protect_all_n, .flash_write_protect_n,
    .debug_mode, .emu_pin_pair_sel, .emu_pair_one, .emu_pair_two, .emu_pair_three,
    .watchdog_on_cfg, .window_mode_off, .watchdog_prescale_sel, .watchdog_prescale_ratio,
    .watchdog_postscale_sel, .watchdog_postscale_ratio, .core_reset_hold, .watchdog_reset_hold);
  flash_model i_flash_model (.clk, .flash_rd, .flash_addr, .base, .word_one, .lat, .flash_rd_valid,
    .flash_rd_data);
  ////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [50:0] g, input logic [50:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t mismatch got %h exp %h", $time, g, e);
    end
  endtask
  function automatic logic [50:0] expv(input logic [23:0] v);
    logic [23:0] c;
    c = v | 24'hFF0420;
    return {c, c[9:8] == 2'b11, c[9:8] == 2'b10, c[9:8] == 2'b01, c[4] ? 8'h80 : 8'h20,
            16'h0001 << c[3:0]};
  endfunction
  function automatic logic [50:0] expf(input logic [23:0] v);
    logic [23:0] c;
    c = v | 24'hFF0420;
    return {37'h0, c[14], c[13], c[12], ~c[11], c[9:8], c[7], c[6], c[4], c[3:0], 1'b0};
  endfunction
  task automatic load(input logic sm, input logic [23:0] v, input logic [3:0] l);
    int i;
    reset = 1'b1;
    small_memory = sm;
    word_one = v;
    lat = l;
    repeat (16) @(posedge clk);
    #1;
    chk({50'h0, core_reset_hold}, {50'h0, 1'b1});
    addrs.delete();
    reset = 1'b0;
    for (i = 0; i < 300 && core_reset_hold !== 1'b0; i++) @(posedge clk);
    #1;
    chk(got, expv(v));
    chk(got2, expf(v));
    for (i = 0; i < 4; i++) chk({35'h0, addrs[i]}, {35'h0, base - 16'h0002 * i[15:0]});
  endtask
  task automatic prog(input logic [23:0] d, input logic s);
    prog_data = d;
    prog_via_scan = s;
    prog_wr = 1'b1;
    @(posedge clk) #1;
    prog_wr = 1'b0;
    w = w & (s ? (d | 24'h004000) : d);
    @(posedge clk) #1;
    chk(got, expv(w));
    chk(got2, expf(w));
  endtask
  task automatic conclude();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    load(1'b0, 24'h006D93, 4'h2);
    load(1'b1, 24'h000A60, 4'h5);
    load(1'b0, 24'h7FFFFF, 4'h0);
    w = 24'h7FFFFF;
    prog(24'h00BFFE, 1'b1);
    prog(24'h00B7FD, 1'b0);
    conclude();
  end
  initial begin
    #20000;
    errors++;
    conclude();
  end
endmodule
bind config_word_one_decode config_word_one_decode_asserts i_config_word_one_decode_asserts (
  .clk, .reset, .prog_wr, .prog_via_scan, .config_word_one, .scan_port_on, .code_protect_all_n,
  .flash_write_protect_n, .debug_mode, .watchdog_prescale_ratio, .watchdog_postscale_ratio,
  .core_reset_hold);
